// [core/fcs_consts.svh]
`ifndef FCS_CONSTS_SVH
`define FCS_CONSTS_SVH

// ---------------------------------------------------------------------
// register indices, byte address is four times the index
// ---------------------------------------------------------------------
`define FCS_CFG_IDX 16'hE706
`define FCS_STAT_IDX 16'hE7F0
`define FCS_CFG_RESET 8'h00

// ---------------------------------------------------------------------
// configuration and status fields
// ---------------------------------------------------------------------
`define FCS_CFG_RATE 0
`define FCS_CFG_SIZE 1
`define FCS_CFG_GAP 2
`define FCS_CFG_XFER_LO 3
`define FCS_CFG_XFER_HI 4
`define FCS_CFG_POL 5
`define FCS_STAT_BUSY 0
`define FCS_STAT_LVL_LO 4
`define FCS_STAT_LVL_HI 8

// ---------------------------------------------------------------------
// word sets
// ---------------------------------------------------------------------
`define FCS_XFER_SAMP 2'h1
`define FCS_XFER_POW 2'h2
`define FCS_WORDS_FULL 16
`define FCS_WORDS_SAMP 7
`define FCS_WORDS_POW 9
`define FCS_POW_BASE 7
`define FCS_FIFO_DEPTH 16

// ---------------------------------------------------------------------
// timing
// ---------------------------------------------------------------------
`define FCS_SYS_NS 50
`define FCS_FAST_NS 125
`define FCS_SLOW_NS 250
`define FCS_PER_CYC(ns) (((ns) + `FCS_SYS_NS - 1) / `FCS_SYS_NS)
`define FCS_GAP_PERIODS 7

`endif

// [core/fcs_pkg.sv]
package fcs_pkg;

    typedef enum logic [3:0] {
        FCS_IDLE = 4'h1,
        FCS_LOAD = 4'h2,
        FCS_SHIFT = 4'h4,
        FCS_GAP = 4'h8
    } fcs_state_t;

    // burst order, first field is sent first
    typedef struct packed {
        logic [31:0] phase_a_current_sample;
        logic [31:0] phase_a_voltage_sample;
        logic [31:0] phase_b_current_sample;
        logic [31:0] phase_b_voltage_sample;
        logic [31:0] phase_c_current_sample;
        logic [31:0] phase_c_voltage_sample;
        logic [31:0] neutral_current_sample;
        logic [31:0] phase_a_apparent_power;
        logic [31:0] phase_b_apparent_power;
        logic [31:0] phase_c_apparent_power;
        logic [31:0] phase_a_active_power;
        logic [31:0] phase_b_active_power;
        logic [31:0] phase_c_active_power;
        logic [31:0] phase_a_fund_reactive_power;
        logic [31:0] phase_b_fund_reactive_power;
        logic [31:0] phase_c_fund_reactive_power;
    } fcs_words_t;

    typedef struct packed {
        logic [17:0] address;
        logic read;
        logic write;
        logic [3:0] byteenable;
        logic [31:0] writedata;
    } fcs_bus_req_t;

endpackage : fcs_pkg

// [core/fcs_capture.sv]
// Behaviour
// - rate bit 0 is 150 ns (about 6.7 MHz), 1 is 4 MHz
// - size 0: one 32-bit package, MSB first
// - size 1: four 8-bit packages, MSB first
// - gap bit: seven idle clock periods between packages
// - set 00: sixteen words, samples then powers
// - set 01: seven current and voltage samples
// - set 10: nine phase power values
// - set 11 behaves as set 00
// - polarity bit 5: 0 active low, 1 high
// - bits 7:6 reserved, no effect
//
// Local design decision: the Avalon-MM slave port.
`timescale 1ns/1ns
`default_nettype none
`include "fcs_consts.svh"

module fcs_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    // fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o,
    output logic [$clog2(DEPTH):0] level_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wp, rp, next_wp, next_rp;

    assign in_ready_o = !((wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]));
    assign out_valid_o = (wp != rp);
    assign out_data_o = mem[rp[AW-1:0]];
    assign level_o = wp - rp;

    always_comb begin
        next_wp = wp;
        next_rp = rp;
        if (in_valid_i && in_ready_o) begin
            next_wp = wp + 1'b1;
        end
        if (out_valid_o && out_ready_i) begin
            next_rp = rp + 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            wp <= '0;
            rp <= '0;
        end else begin
            wp <= next_wp;
            rp <= next_rp;
        end
        if (in_valid_i && in_ready_o) begin
            mem[wp[AW-1:0]] <= in_data_i;
        end
    end
endmodule : fcs_fifo

module fcs_capture (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    // register bus
    input wire fcs_pkg::fcs_bus_req_t avs_req_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // word source
    input wire logic sample_strobe_i,
    input wire fcs_pkg::fcs_words_t words_i,
    // capture port pins
    output logic capture_clock_out_o,
    output logic capture_data_out_o,
    output logic capture_frame_select_out_o
);
    localparam int PER_FAST = `FCS_PER_CYC(`FCS_FAST_NS);
    localparam int PER_SLOW = `FCS_PER_CYC(`FCS_SLOW_NS);
    localparam int FAW = $clog2(`FCS_FIFO_DEPTH);

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);

    function automatic logic hit(input logic [17:0] a, input logic [15:0] idx);
        hit = (a == {idx, 2'b00});
    endfunction : hit

    function automatic logic [4:0] burst_len(input logic [1:0] x);
        case (x)
            `FCS_XFER_SAMP: burst_len = 5'(`FCS_WORDS_SAMP);
            `FCS_XFER_POW: burst_len = 5'(`FCS_WORDS_POW);
            default: burst_len = 5'(`FCS_WORDS_FULL);
        endcase
    endfunction : burst_len

    // -----------------------------------------------------------------
    // register bus slave
    // -----------------------------------------------------------------
    logic ack, next_ack;
    logic [7:0] cfg, next_cfg;
    logic [31:0] next_rdata;
    logic [FAW:0] f_level;
    fcs_pkg::fcs_state_t st, next_st;
    logic req;

    assign req = avs_req_i.read || avs_req_i.write;
    assign avs_waitrequest_o = req && !ack;

    always_comb begin
        next_ack = req && !ack;
        next_cfg = cfg;
        next_rdata = avs_readdata_o;
        if (avs_req_i.write && ack && avs_req_i.byteenable[0] && hit(avs_req_i.address, `FCS_CFG_IDX)) begin
            next_cfg = avs_req_i.writedata[7:0];
        end
        if (avs_req_i.read && !ack) begin
            next_rdata = '0;
            if (hit(avs_req_i.address, `FCS_CFG_IDX)) begin
                next_rdata[7:0] = cfg;
            end else if (hit(avs_req_i.address, `FCS_STAT_IDX)) begin
                next_rdata[`FCS_STAT_BUSY] = (st != fcs_pkg::FCS_IDLE);
                next_rdata[`FCS_STAT_LVL_HI:`FCS_STAT_LVL_LO] = f_level;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            ack <= 1'b0;
            cfg <= `FCS_CFG_RESET;
            avs_readdata_o <= '0;
        end else begin
            ack <= next_ack;
            cfg <= next_cfg;
            avs_readdata_o <= next_rdata;
        end
    end

    // -----------------------------------------------------------------
    // loader: selected words into the fifo
    // -----------------------------------------------------------------
    logic [4:0] ld_rem, next_ld_rem;
    logic [3:0] ld_idx, next_ld_idx, ld_base, next_ld_base;
    logic [511:0] flat;
    logic [31:0] push_data, f_data;
    logic f_ready, f_valid, pop, start;

    assign flat = words_i;
    assign push_data = flat[511 - 32 * 32'(ld_base + ld_idx) -: 32];
    assign start = (st == fcs_pkg::FCS_IDLE) && sample_strobe_i;

    always_comb begin
        next_ld_rem = ld_rem;
        next_ld_idx = ld_idx;
        next_ld_base = ld_base;
        if (start) begin
            next_ld_rem = burst_len(cfg[`FCS_CFG_XFER_HI:`FCS_CFG_XFER_LO]);
            next_ld_idx = '0;
            next_ld_base = (cfg[`FCS_CFG_XFER_HI:`FCS_CFG_XFER_LO] == `FCS_XFER_POW) ?
                4'(`FCS_POW_BASE) : 4'h0;
        end else if (ld_rem != 5'h00 && f_ready) begin
            next_ld_rem = ld_rem - 5'h01;
            next_ld_idx = ld_idx + 4'h1;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            ld_rem <= '0;
            ld_idx <= '0;
            ld_base <= '0;
        end else begin
            ld_rem <= next_ld_rem;
            ld_idx <= next_ld_idx;
            ld_base <= next_ld_base;
        end
    end

    fcs_fifo #(
        .WIDTH(32),
        .DEPTH(`FCS_FIFO_DEPTH)
    ) fcs_fifo_inst (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .in_valid_i(ld_rem != 5'h00),
        .in_ready_o(f_ready),
        .in_data_i(push_data),
        .out_valid_o(f_valid),
        .out_ready_i(pop),
        .out_data_o(f_data),
        .level_o(f_level)
    );

    // -----------------------------------------------------------------
    // serialiser
    // -----------------------------------------------------------------
    logic [7:0] run, next_run;
    logic [2:0] ph, next_ph, gcnt, next_gcnt, per, low;
    logic [4:0] bitn, next_bitn, sh_rem, next_sh_rem;
    logic [31:0] shreg, next_shreg;
    logic next_sck, next_sdo, next_cs, ph_last, word_end, pkt_end, need;

    // bits 7:6 of run are never looked at
    assign per = run[`FCS_CFG_RATE] ? 3'(PER_SLOW) : 3'(PER_FAST);
    assign low = per >> 1;
    assign ph_last = (ph == per - 3'h1);
    assign word_end = (bitn == 5'h1F);
    assign pkt_end = word_end || (run[`FCS_CFG_SIZE] && bitn[2:0] == 3'h7);

    always_comb begin
        next_st = st;
        next_run = run;
        next_ph = ph;
        next_gcnt = gcnt;
        next_bitn = bitn;
        next_sh_rem = sh_rem;
        next_shreg = shreg;
        need = 1'b0;
        pop = 1'b0;
        case (st)
            fcs_pkg::FCS_IDLE: begin
                next_run = cfg;
                if (sample_strobe_i) begin
                    next_sh_rem = burst_len(cfg[`FCS_CFG_XFER_HI:`FCS_CFG_XFER_LO]);
                    next_st = fcs_pkg::FCS_LOAD;
                end
            end
            fcs_pkg::FCS_LOAD: begin
                need = 1'b1;
            end
            fcs_pkg::FCS_SHIFT: begin
                if (ph_last) begin
                    next_ph = '0;
                    next_bitn = bitn + 5'h01;
                    next_shreg = {shreg[30:0], 1'b0};
                    if (pkt_end) begin
                        if (word_end && sh_rem == 5'h00) begin
                            next_st = fcs_pkg::FCS_IDLE;
                        end else if (run[`FCS_CFG_GAP]) begin
                            next_st = fcs_pkg::FCS_GAP;
                            next_gcnt = '0;
                        end else if (word_end) begin
                            need = 1'b1;
                        end
                    end
                end else begin
                    next_ph = ph + 3'h1;
                end
            end
            fcs_pkg::FCS_GAP: begin
                if (ph_last) begin
                    next_ph = '0;
                    if (gcnt == 3'(`FCS_GAP_PERIODS - 1)) begin
                        if (bitn == 5'h00) begin
                            need = 1'b1;
                        end else begin
                            next_st = fcs_pkg::FCS_SHIFT;
                        end
                    end else begin
                        next_gcnt = gcnt + 3'h1;
                    end
                end else begin
                    next_ph = ph + 3'h1;
                end
            end
            default: begin
                next_st = fcs_pkg::FCS_IDLE;
            end
        endcase
        if (need) begin
            next_ph = '0;
            if (f_valid) begin
                pop = 1'b1;
                next_shreg = f_data;
                next_sh_rem = sh_rem - 5'h01;
                next_st = fcs_pkg::FCS_SHIFT;
            end else begin
                next_st = fcs_pkg::FCS_LOAD;
            end
        end
        // clock low in first part of each bit, rising edge mid bit
        next_sck = !(next_st == fcs_pkg::FCS_SHIFT && next_ph < low);
        next_sdo = (next_st == fcs_pkg::FCS_SHIFT) ? next_shreg[31] : 1'b0;
        next_cs = (next_st != fcs_pkg::FCS_IDLE) ? next_run[`FCS_CFG_POL] : !next_run[`FCS_CFG_POL];
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            st <= fcs_pkg::FCS_IDLE;
            run <= `FCS_CFG_RESET;
            ph <= '0;
            gcnt <= '0;
            bitn <= '0;
            sh_rem <= '0;
            shreg <= '0;
            capture_clock_out_o <= 1'b1;
            capture_data_out_o <= 1'b0;
            capture_frame_select_out_o <= 1'b1;
        end else begin
            st <= next_st;
            run <= next_run;
            ph <= next_ph;
            gcnt <= next_gcnt;
            bitn <= next_bitn;
            sh_rem <= next_sh_rem;
            shreg <= next_shreg;
            capture_clock_out_o <= next_sck;
            capture_data_out_o <= next_sdo;
            capture_frame_select_out_o <= next_cs;
        end
    end

    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------
    a_fast_clock_low: assert property ($fell(capture_clock_out_o) && !run[`FCS_CFG_RATE]
        |=> capture_clock_out_o)
        else $error("fast capture clock low phase wrong");
    a_slow_clock_low: assert property ($fell(capture_clock_out_o) && run[`FCS_CFG_RATE]
        |=> !capture_clock_out_o ##1 capture_clock_out_o)
        else $error("slow capture clock low phase wrong");
    a_word_package_whole: assert property (st == fcs_pkg::FCS_SHIFT && ph_last && !run[`FCS_CFG_SIZE]
        && bitn != 5'h1F |=> st == fcs_pkg::FCS_SHIFT)
        else $error("32-bit package interrupted");
    a_byte_package_end: assert property (st == fcs_pkg::FCS_SHIFT && next_st == fcs_pkg::FCS_GAP
        && run[`FCS_CFG_SIZE] |-> bitn[2:0] == 3'h7)
        else $error("byte package not 8 bits");
    a_gap_only_enabled: assert property (st == fcs_pkg::FCS_SHIFT && next_st == fcs_pkg::FCS_GAP
        |-> run[`FCS_CFG_GAP] && capture_clock_out_o)
        else $error("gap without gap enable");
    a_full_set_len: assert property (start && cfg[`FCS_CFG_XFER_HI:`FCS_CFG_XFER_LO] != `FCS_XFER_SAMP
        && cfg[`FCS_CFG_XFER_HI:`FCS_CFG_XFER_LO] != `FCS_XFER_POW |=> sh_rem == 5'h10 && ld_base == 4'h0)
        else $error("full set length wrong");
    a_samp_set_len: assert property (start && cfg[`FCS_CFG_XFER_HI:`FCS_CFG_XFER_LO] == `FCS_XFER_SAMP
        |=> sh_rem == 5'h07 && ld_base == 4'h0)
        else $error("sample set length wrong");
    a_pow_set_len: assert property (start && cfg[`FCS_CFG_XFER_HI:`FCS_CFG_XFER_LO] == `FCS_XFER_POW
        |=> sh_rem == 5'h09 && ld_base == 4'h7)
        else $error("power set length wrong");
    a_select_level: assert property (st != fcs_pkg::FCS_IDLE
        |-> capture_frame_select_out_o == run[`FCS_CFG_POL])
        else $error("frame select level wrong in burst");
    a_clock_in_frame: assert property ($fell(capture_clock_out_o)
        |-> capture_frame_select_out_o == run[`FCS_CFG_POL])
        else $error("capture clock outside frame");
endmodule : fcs_capture

`default_nettype wire

// [tb/fcs_rx_model.sv]
`timescale 1ns/1ns
`default_nettype none

module fcs_rx_model (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    // bench control
    input wire logic arm_i,
    input wire logic pol_i,
    // capture port pins
    input wire logic sclk_i,
    input wire logic sdata_i,
    input wire logic sel_i,
    // received words and timing
    output logic [31:0] word_o,
    output logic word_valid_o,
    output logic [15:0] frames_o,
    output logic [15:0] ends_o,
    output logic [15:0] min_per_o,
    output logic [15:0] max_per_o
);
    logic act, act_q, sclk_q, first, vld;
    logic [15:0] cnt, fr, en, mn, mx;
    logic [4:0] nbit;
    logic [31:0] shreg;

    // ---------------------------------------------------------------------
    // receiver, polls the capture clock with the system clock
    // ---------------------------------------------------------------------
    always @(posedge clk_sys_i) begin
        act = arm_i && (sel_i === pol_i);
        vld = 1'b0;
        if (sys_rst_i) begin
            act_q = 1'b0;
            sclk_q = 1'b1;
            fr = '0;
            en = '0;
            mn = 16'hFFFF;
            mx = '0;
        end else begin
            if (act && !act_q) begin
                fr++;
                first = 1'b1;
                cnt = '0;
                nbit = '0;
                mn = 16'hFFFF;
                mx = '0;
            end
            if (!act && act_q) en++;
            if (act) begin
                cnt++;
                // take a bit on each rising capture clock inside the frame
                if (!sclk_q && sclk_i) begin
                    shreg = {shreg[30:0], sdata_i};
                    if (!first && cnt < mn) mn = cnt;
                    if (!first && cnt > mx) mx = cnt;
                    first = 1'b0;
                    cnt = '0;
                    vld = (nbit == 5'h1F);
                    nbit++;
                end
            end
            act_q = act;
            sclk_q = sclk_i;
        end
        word_valid_o <= vld;
        word_o <= shreg;
        frames_o <= fr;
        ends_o <= en;
        min_per_o <= mn;
        max_per_o <= mx;
    end
endmodule : fcs_rx_model

`default_nettype wire

// [tb/fcs_capture_tb.sv]
`timescale 1ns/1ns
`default_nettype none
`include "fcs_consts.svh"
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin num_errors++; \
    $display("[ERR] t=%0t got=%0h exp=%0h", $time, (a), (e)); end end

module fcs_capture_tb;
    localparam logic [17:0] CFG_A = {`FCS_CFG_IDX, 2'b00};
    localparam logic [17:0] STAT_A = {`FCS_STAT_IDX, 2'b00};
    logic clk_sys_i, sys_rst_i, sample_strobe_i, arm, pol;
    fcs_pkg::fcs_bus_req_t req;
    fcs_pkg::fcs_words_t words;
    logic [31:0] rdata, rx_w, e_w, e_r;
    logic wait_o, sclk, sdat, fsel, rx_v;
    logic [15:0] frames, ends, pmin, pmax;
    logic [31:0] seed = 32'hF794;
    logic [7:0] cfgs [6] = '{8'h00, 8'h0B, 8'h34, 8'hDF, 8'h2A, 8'h13};
    int num_errors = 0;
    int n_tests = 0;
    int nb = 0;
    logic [31:0] exp_q[$];
    logic [31:0] rd_q[$];

    fcs_capture fcs_capture_inst (
        .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
        .avs_req_i(req), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_o),
        .sample_strobe_i(sample_strobe_i), .words_i(words),
        .capture_clock_out_o(sclk), .capture_data_out_o(sdat), .capture_frame_select_out_o(fsel)
    );

    fcs_rx_model fcs_rx_model_inst (
        .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .arm_i(arm), .pol_i(pol),
        .sclk_i(sclk), .sdata_i(sdat), .sel_i(fsel), .word_o(rx_w), .word_valid_o(rx_v),
        .frames_o(frames), .ends_o(ends), .min_per_o(pmin), .max_per_o(pmax)
    );

    initial begin
        clk_sys_i = 1'b0;
        forever #25 clk_sys_i = ~clk_sys_i;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    task automatic close_out();
        if (num_errors == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : close_out

    // ---------------------------------------------------------------------
    // avalon master, holds the request until waitrequest is seen low
    // ---------------------------------------------------------------------
    task automatic bus(input logic rd, input logic [17:0] a, input logic [31:0] d, input logic [3:0] be);
        int n;
        n = 0;
        req.address <= a;
        req.read <= rd;
        req.write <= !rd;
        req.byteenable <= be;
        req.writedata <= d;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (wait_o !== 1'b0 && n < 40);
        if (n >= 40) begin
            num_errors++;
            close_out();
        end
        req.read <= 1'b0;
        req.write <= 1'b0;
        @(posedge clk_sys_i);
    endtask : bus

    task automatic rd_chk(input logic [17:0] a, input logic [31:0] e);
        rd_q.push_back(e);
        bus(1'b1, a, 32'h0, 4'hF);
    endtask : rd_chk

    // ---------------------------------------------------------------------
    // one burst under a given configuration
    // ---------------------------------------------------------------------
    task automatic burst(input logic [7:0] cfg);
        int n, k, lo, hi, p;
        arm <= 1'b0;
        bus(1'b0, CFG_A, {24'h0, cfg}, 4'hF);
        rd_chk(CFG_A, {24'h0, cfg});
        pol <= cfg[5];
        lo = (cfg[4:3] == 2'b10) ? 7 : 0;
        hi = (cfg[4:3] == 2'b01) ? 7 : 16;
        for (k = 0; k < 16; k++) begin
            seed = xs(seed);
            words[511 - 32 * k -: 32] <= seed;
            if (k >= lo && k < hi) exp_q.push_back(seed);
        end
        @(posedge clk_sys_i);
        arm <= 1'b1;
        sample_strobe_i <= 1'b1;
        @(posedge clk_sys_i);
        sample_strobe_i <= 1'b0;
        // a second strobe while busy must not start another burst
        repeat (60) @(posedge clk_sys_i);
        sample_strobe_i <= 1'b1;
        @(posedge clk_sys_i);
        sample_strobe_i <= 1'b0;
        // busy, one word already taken from the fifo
        rd_chk(STAT_A, 32'((hi - lo - 1) * 16 + 1));
        nb++;
        n = 0;
        while (ends != nb[15:0] && n < 40000) begin
            @(posedge clk_sys_i);
            n++;
        end
        if (n >= 40000) begin
            num_errors++;
            close_out();
        end
        repeat (3) @(posedge clk_sys_i);
        p = cfg[0] ? 5 : 3;
        `CHK(exp_q.size(), 0)
        `CHK(frames, nb[15:0])
        `CHK(pmin, p[15:0])
        `CHK(pmax, 16'(cfg[2] ? 8 * p : p))
        `CHK(fsel, ~cfg[5])
        `CHK(sclk, 1'b1)
    endtask : burst

    // ---------------------------------------------------------------------
    // result watcher, pairs each result with the oldest note
    // ---------------------------------------------------------------------
    always @(posedge clk_sys_i) begin
        if (req.read === 1'b1 && wait_o === 1'b0 && rd_q.size() > 0) begin
            e_r = rd_q.pop_front();
            `CHK(rdata, e_r)
        end
        if (rx_v === 1'b1) begin
            `CHK(exp_q.size() != 0, 1'b1)
            if (exp_q.size() != 0) begin
                e_w = exp_q.pop_front();
                `CHK(rx_w, e_w)
            end
        end
    end

    // ---------------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------------
    initial begin
        sys_rst_i = 1'b1;
        sample_strobe_i = 1'b0;
        req = '0;
        words = '0;
        arm = 1'b0;
        pol = 1'b0;
        repeat (10) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_sys_i);
        `CHK(fsel, 1'b1)
        `CHK(sclk, 1'b1)
        `CHK(sdat, 1'b0)
        rd_chk(CFG_A, 32'h0);
        rd_chk(18'h00100, 32'h0);
        rd_chk(STAT_A, 32'h0);
        bus(1'b0, CFG_A, 32'hFF, 4'hE);
        rd_chk(CFG_A, 32'h0);
        foreach (cfgs[i]) burst(cfgs[i]);
        close_out();
    end
endmodule : fcs_capture_tb

`default_nettype wire
